// ===== rtl/pfs_regs.vh
// constants for the pin function select block
`ifndef PFS_REGS_VH
`define PFS_REGS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PFS_ADDR_CFG     8'h00
`define PFS_ADDR_GPDATA  8'h04
`define PFS_ADDR_GPDIR   8'h08
`define PFS_ADDR_GPIN    8'h0c
`define PFS_ADDR_GPIRQ   8'h10
`define PFS_ADDR_STATUS  8'h14
`define PFS_ADDR_EEPROM  8'h18
`define PFS_ADDR_SUBSYS  8'h1c

// ----------------------------------------
// reset values
// ----------------------------------------
`define PFS_RST_CFG      8'h00
`define PFS_RST_GP       12'h000
`define PFS_RST_WORD     32'h0000_0000
`define PFS_RST_MODE     3'h7

// ----------------------------------------
// mode strap codes
// ----------------------------------------
`define PFS_MODE_LB      3'h0
`define PFS_MODE_PP      3'h1
`define PFS_MODE_SSID    3'h2
`define PFS_MODE_LB_UB   3'h3
`define PFS_MODE_LB_ENH  3'h4
`define PFS_MODE_PP_ENH  3'h5
`define PFS_MODE_RSVD    3'h6
`define PFS_MODE_ALONE   3'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define PFS_CFG_PIN1_HI  6
`define PFS_CFG_PIN1_LO  5
`define PFS_CFG_PIN2     7
`define PFS_PIN_ZERO     0
`define PFS_PIN_ONE      1
`define PFS_PIN_TWO      2
`define PFS_PIN_ELEVEN   11
`define PFS_EE_CLK       0
`define PFS_EEPROM_SELECT_OUT        1
`define PFS_EEPROM_DATA_OUT        2
`define PFS_EEPROM_DATA_IN        3
`define PFS_ST_MODE_LO   0
`define PFS_ST_MODE_HI   2
`define PFS_ST_FORM      3
`define PFS_ST_PWR       4
`define PFS_ST_VALID     5

// ----------------------------------------
// timing
// ----------------------------------------
`define PFS_FILL_CYCLES  3'h5
`define PFS_CNT_ONE      3'h1

`endif

// ===== rtl/pfs_top.v
// pin function select: strap decode, general pin roles, eeprom pins, apb registers
`include "pfs_regs.vh"

// What this block does
// - pin zero is general i/o or interrupt source in modes 000, 011, 100
// - pin zero is driven constantly low in modes 001 and 101
// - outside modes 010, 110, 111: pin one is general i/o when config bits 6:5 are 00, else driven low
// - config bit 7 clear, outside modes 010, 110, 111: pin two is general i/o or interrupt source
// - config bit 7 set, outside modes 010, 110, 111: pin two is power event input raising function 1 event
// - pins three to ten are general i/o except in modes 010, 110, 111
// - pin eleven is general i/o in modes 000, 001, 010
// - pin eleven is bus form strap in modes 011, 100, 101: low standard, high mini
// - device drives eeprom clock and active-high eeprom select
// - data shifts out on data-out pin; eeprom output sampled on data-in pin
// - data-in pin has pull-up, reads high when no eeprom fitted
// - mode 000: quad uart plus 8-bit local bus, compatible layout
// - mode 001: quad uart plus parallel port, compatible layout
// - mode 010: function 1 unusable, local bus pins set subsystem ids
// - mode 011: uarts in own base regions, local bus enhanced
// - mode 100: quad uart plus local bus, enhanced
// - mode 101: quad uart plus parallel port, enhanced
// - mode 111 standalone without host bus; 110 reserved, not strapped
module pfs_top (
  // clock, reset, enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // straps
  input  wire [2:0]  mode_pins,
  input  wire [31:0] id_pins,
  // general pins
  input  wire [11:0] gp_in,
  output reg  [11:0] gp_out,
  output reg  [11:0] gp_oe,
  output reg         gp_irq,
  output reg         pwr_event_req,
  // eeprom
  output reg         eeprom_clock_out,
  output reg         eeprom_select_out,
  output reg         eeprom_data_out,
  input  wire        eeprom_data_in,
  // function roles
  output reg         straps_valid,
  output reg         f1_local_bus,
  output reg         f1_parallel,
  output reg         f1_disabled,
  output reg         enhanced_mode,
  output reg         uart_unique_bars,
  output reg         subsys_from_pins,
  output reg         standalone,
  output reg         mode_reserved,
  output reg         bus_form_strap,
  output reg  [15:0] subsys_id,
  output reg  [15:0] subsys_vid
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam ST_FILL = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg [1:0]  state_r;
  reg [2:0]  fill_r;
  reg [2:0]  mode_r;
  reg [7:0]  local_config_word_r;
  reg [11:0] gp_data_r;
  reg [11:0] gp_dir_r;
  reg [11:0] gp_irq_en_r;
  reg [2:0]  ee_ctl_r;

  // three-stage sync chains
  reg [11:0] gp_s1_r;
  reg [11:0] gp_s2_r;
  reg [11:0] gp_s3_r;
  reg [11:0] gp_filt_r;
  reg [2:0]  md_s1_r;
  reg [2:0]  md_s2_r;
  reg [2:0]  md_s3_r;
  reg [2:0]  md_filt_r;
  reg [31:0] id_s1_r;
  reg [31:0] id_s2_r;
  reg [31:0] id_s3_r;
  reg [31:0] id_filt_r;
  reg        di_s1_r;
  reg        di_s2_r;
  reg        di_s3_r;
  reg        di_filt_r;

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  // pins that behave as general i/o in this mode and config
  function [11:0] pfs_gpio_mask;
    input [2:0] md;
    input [7:0] cfg;
    reg   [11:0] m;
    begin
      m = `PFS_RST_GP;
      if (md != `PFS_MODE_SSID && md != `PFS_MODE_RSVD &&
          md != `PFS_MODE_ALONE) begin
        m = ~`PFS_RST_GP;
        m[`PFS_PIN_ZERO] = (md == `PFS_MODE_LB) || (md == `PFS_MODE_LB_UB) ||
                           (md == `PFS_MODE_LB_ENH);
        m[`PFS_PIN_ONE] = (cfg[`PFS_CFG_PIN1_HI:`PFS_CFG_PIN1_LO] == 2'b00);
        m[`PFS_PIN_TWO] = ~cfg[`PFS_CFG_PIN2];
        m[`PFS_PIN_ELEVEN] = (md == `PFS_MODE_LB) || (md == `PFS_MODE_PP);
      end
      if (md == `PFS_MODE_SSID)
        m[`PFS_PIN_ELEVEN] = 1'b1;
      pfs_gpio_mask = m;
    end
  endfunction

  // pins that are held driven low in this mode and config
  function [11:0] pfs_low_mask;
    input [2:0] md;
    input [7:0] cfg;
    reg   [11:0] m;
    begin
      m = `PFS_RST_GP;
      if (md != `PFS_MODE_SSID && md != `PFS_MODE_RSVD &&
          md != `PFS_MODE_ALONE) begin
        m[`PFS_PIN_ZERO] = (md == `PFS_MODE_PP) || (md == `PFS_MODE_PP_ENH);
        m[`PFS_PIN_ONE] = (cfg[`PFS_CFG_PIN1_HI:`PFS_CFG_PIN1_LO] != 2'b00);
      end
      pfs_low_mask = m;
    end
  endfunction

  // true for modes where pin eleven is the form strap
  function pfs_form_mode;
    input [2:0] md;
    begin
      pfs_form_mode = (md == `PFS_MODE_LB_UB) || (md == `PFS_MODE_LB_ENH) ||
                      (md == `PFS_MODE_PP_ENH);
    end
  endfunction

  // address is a mapped register
  function pfs_mapped;
    input [7:0] a;
    begin
      case (a)
        `PFS_ADDR_CFG,
        `PFS_ADDR_GPDATA,
        `PFS_ADDR_GPDIR,
        `PFS_ADDR_GPIN,
        `PFS_ADDR_GPIRQ,
        `PFS_ADDR_STATUS,
        `PFS_ADDR_EEPROM,
        `PFS_ADDR_SUBSYS: pfs_mapped = 1'b1;
        default:          pfs_mapped = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // a bit only moves when stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_s1_r   <= `PFS_RST_GP;
      gp_s2_r   <= `PFS_RST_GP;
      gp_s3_r   <= `PFS_RST_GP;
      gp_filt_r <= `PFS_RST_GP;
      md_s1_r   <= `PFS_RST_MODE;
      md_s2_r   <= `PFS_RST_MODE;
      md_s3_r   <= `PFS_RST_MODE;
      md_filt_r <= `PFS_RST_MODE;
      id_s1_r   <= `PFS_RST_WORD;
      id_s2_r   <= `PFS_RST_WORD;
      id_s3_r   <= `PFS_RST_WORD;
      id_filt_r <= `PFS_RST_WORD;
      di_s1_r   <= 1'b1;
      di_s2_r   <= 1'b1;
      di_s3_r   <= 1'b1;
      di_filt_r <= 1'b1;
    end else if (ce) begin
      gp_s1_r   <= gp_in;
      gp_s2_r   <= gp_s1_r;
      gp_s3_r   <= gp_s2_r;
      gp_filt_r <= (~(gp_s2_r ^ gp_s3_r) & gp_s3_r) | ((gp_s2_r ^ gp_s3_r) & gp_filt_r);
      md_s1_r   <= mode_pins;
      md_s2_r   <= md_s1_r;
      md_s3_r   <= md_s2_r;
      md_filt_r <= (~(md_s2_r ^ md_s3_r) & md_s3_r) | ((md_s2_r ^ md_s3_r) & md_filt_r);
      id_s1_r   <= id_pins;
      id_s2_r   <= id_s1_r;
      id_s3_r   <= id_s2_r;
      id_filt_r <= (~(id_s2_r ^ id_s3_r) & id_s3_r) | ((id_s2_r ^ id_s3_r) & id_filt_r);
      di_s1_r   <= eeprom_data_in;
      di_s2_r   <= di_s1_r;
      di_s3_r   <= di_s2_r;
      if (di_s2_r == di_s3_r)
        di_filt_r <= di_s3_r;
    end
  end

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // waits for the chains to fill, then latches once; the reserved
  // code falls back to no pin functions rather than guessing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r          <= ST_FILL;
      fill_r           <= `PFS_FILL_CYCLES;
      mode_r           <= `PFS_RST_MODE;
      straps_valid     <= 1'b0;
      f1_local_bus     <= 1'b0;
      f1_parallel      <= 1'b0;
      f1_disabled      <= 1'b0;
      enhanced_mode    <= 1'b0;
      uart_unique_bars <= 1'b0;
      subsys_from_pins <= 1'b0;
      standalone       <= 1'b0;
      mode_reserved    <= 1'b0;
      bus_form_strap   <= 1'b0;
      subsys_id        <= 16'h0000;
      subsys_vid       <= 16'h0000;
    end else if (ce) begin
      case (state_r)
        ST_FILL: begin
          if (fill_r != `PFS_CNT_ONE) begin
            fill_r <= fill_r - `PFS_CNT_ONE;
          end else begin
            state_r          <= ST_RUN;
            straps_valid     <= 1'b1;
            mode_r           <= md_filt_r;
            f1_local_bus     <= (md_filt_r == `PFS_MODE_LB) ||
                                (md_filt_r == `PFS_MODE_LB_UB) ||
                                (md_filt_r == `PFS_MODE_LB_ENH);
            f1_parallel      <= (md_filt_r == `PFS_MODE_PP) ||
                                (md_filt_r == `PFS_MODE_PP_ENH);
            f1_disabled      <= (md_filt_r == `PFS_MODE_SSID);
            enhanced_mode    <= (md_filt_r == `PFS_MODE_LB_UB) ||
                                (md_filt_r == `PFS_MODE_LB_ENH) ||
                                (md_filt_r == `PFS_MODE_PP_ENH);
            uart_unique_bars <= (md_filt_r == `PFS_MODE_LB_UB);
            subsys_from_pins <= (md_filt_r == `PFS_MODE_SSID);
            standalone       <= (md_filt_r == `PFS_MODE_ALONE);
            mode_reserved    <= (md_filt_r == `PFS_MODE_RSVD);
            bus_form_strap   <= pfs_form_mode(md_filt_r) &
                                gp_filt_r[`PFS_PIN_ELEVEN];
            if (md_filt_r == `PFS_MODE_SSID) begin
              subsys_vid <= id_filt_r[31:16];
              subsys_id  <= id_filt_r[15:0];
            end
          end
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_FILL;
          fill_r  <= `PFS_FILL_CYCLES;
        end
      endcase
    end
  end

  // ----------------------------------------
  // general pin drive
  // ----------------------------------------
  // pins stay undriven until the straps are known, so nothing fights
  // a strap the board is still presenting
  wire [11:0] gpio_mask_w = pfs_gpio_mask(mode_r, local_config_word_r);
  wire [11:0] low_mask_w  = pfs_low_mask(mode_r, local_config_word_r);
  wire        pwr_mode_w  = (mode_r != `PFS_MODE_SSID) && (mode_r != `PFS_MODE_RSVD) &&
                            (mode_r != `PFS_MODE_ALONE);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_out        <= `PFS_RST_GP;
      gp_oe         <= `PFS_RST_GP;
      gp_irq        <= 1'b0;
      pwr_event_req <= 1'b0;
    end else if (ce) begin
      if (straps_valid) begin
        gp_out <= gp_data_r & gp_dir_r & gpio_mask_w;
        gp_oe  <= (gp_dir_r & gpio_mask_w) | low_mask_w;
        gp_irq <= |(gp_filt_r & gp_irq_en_r & gpio_mask_w);
        pwr_event_req <= pwr_mode_w & local_config_word_r[`PFS_CFG_PIN2] &
                         gp_filt_r[`PFS_PIN_TWO];
      end else begin
        gp_out        <= `PFS_RST_GP;
        gp_oe         <= `PFS_RST_GP;
        gp_irq        <= 1'b0;
        pwr_event_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // eeprom pins
  // ----------------------------------------
  // software bit-bangs the link; select only rises on its request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_clock_out  <= 1'b0;
      eeprom_select_out <= 1'b0;
      eeprom_data_out   <= 1'b0;
    end else if (ce) begin
      eeprom_clock_out  <= ee_ctl_r[`PFS_EE_CLK];
      eeprom_select_out <= ee_ctl_r[`PFS_EEPROM_SELECT_OUT];
      eeprom_data_out   <= ee_ctl_r[`PFS_EEPROM_DATA_OUT];
    end
  end

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  wire setup_w  = psel & ~penable;
  wire access_w = psel & penable & pready;
  reg  [31:0] rd_w;

  always @* begin
    rd_w = `PFS_RST_WORD;
    case (paddr)
      `PFS_ADDR_CFG:    rd_w[7:0]  = local_config_word_r;
      `PFS_ADDR_GPDATA: rd_w[11:0] = gp_data_r;
      `PFS_ADDR_GPDIR:  rd_w[11:0] = gp_dir_r;
      `PFS_ADDR_GPIN:   rd_w[11:0] = gp_filt_r & gpio_mask_w;
      `PFS_ADDR_GPIRQ:  rd_w[11:0] = gp_irq_en_r;
      `PFS_ADDR_STATUS: begin
        rd_w[`PFS_ST_MODE_HI:`PFS_ST_MODE_LO] = mode_r;
        rd_w[`PFS_ST_FORM]  = bus_form_strap;
        rd_w[`PFS_ST_PWR]   = pwr_event_req;
        rd_w[`PFS_ST_VALID] = straps_valid;
      end
      `PFS_ADDR_EEPROM: begin
        rd_w[2:0]         = ee_ctl_r;
        rd_w[`PFS_EEPROM_DATA_IN]  = di_filt_r;
      end
      `PFS_ADDR_SUBSYS: rd_w = {subsys_vid, subsys_id};
      default:          rd_w = `PFS_RST_WORD;
    endcase
  end

  // one wait-free access cycle: ready rises in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= `PFS_RST_WORD;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup_w;
      if (setup_w) begin
        prdata  <= pwrite ? `PFS_RST_WORD : rd_w;
        pslverr <= ~pfs_mapped(paddr);
      end else if (access_w) begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_config_word_r <= `PFS_RST_CFG;
      gp_data_r           <= `PFS_RST_GP;
      gp_dir_r            <= `PFS_RST_GP;
      gp_irq_en_r         <= `PFS_RST_GP;
      ee_ctl_r            <= 3'h0;
    end else if (ce && access_w && pwrite) begin
      case (paddr)
        `PFS_ADDR_CFG:    local_config_word_r <= pwdata[7:0];
        `PFS_ADDR_GPDATA: gp_data_r           <= pwdata[11:0];
        `PFS_ADDR_GPDIR:  gp_dir_r            <= pwdata[11:0];
        `PFS_ADDR_GPIRQ:  gp_irq_en_r         <= pwdata[11:0];
        `PFS_ADDR_EEPROM: ee_ctl_r            <= pwdata[2:0];
        default:          ee_ctl_r            <= ee_ctl_r;
      endcase
    end
  end

endmodule

// ===== tb/pfs_board.sv
// board straps, general pin levels and serial eeprom model
module pfs_board (
  // strap and pin levels set by the bench
  input  logic [2:0]  mode,
  input  logic [11:0] gen,
  // device pins
  output logic [2:0]  mode_pins,
  output logic [31:0] id_pins,
  output logic [11:0] gp_in,
  input  logic        eeprom_clock_out,
  input  logic        eeprom_select_out,
  input  logic        eeprom_data_out,
  output logic        eeprom_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ID = 32'h5a3c_96e1; // arbitrary value
  logic q = 1'b1;
  assign mode_pins = mode;
  assign id_pins = ID;
  // standalone board grounds every general pin
  assign gp_in = (mode == 3'h7) ? 12'h000 : gen;
  always @(posedge eeprom_clock_out)
    if (eeprom_select_out) q <= ~eeprom_data_out;
  // deselected part floats, pull-up wins
  assign eeprom_data_in = eeprom_select_out ? q : 1'b1;
endmodule

// ===== tb/pfs_chk_assertions.sv
// concurrent checks on the pin function select ports
module pfs_chk (
  // clock and reset
  input logic        pclk,
  input logic        presetn,
  input logic        ce,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pready,
  input logic        pslverr,
  // pins and roles
  input logic [2:0]  mode_pins,
  input logic [11:0] gp_in,
  input logic [11:0] gp_oe,
  input logic [11:0] gp_out,
  input logic        pwr_event_req,
  input logic        straps_valid,
  input logic        f1_local_bus,
  input logic        f1_parallel,
  input logic        enhanced_mode,
  input logic        subsys_from_pins,
  input logic        standalone,
  input logic        mode_reserved,
  input logic        bus_form_strap
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] ro;
  logic       vv;
  assign ro = {f1_local_bus, f1_parallel, enhanced_mode, subsys_from_pins,
               standalone, mode_reserved, bus_form_strap};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  always @(posedge pclk or negedge presetn)
    if (!presetn) vv <= 1'b0;
    else vv <= straps_valid;
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("pready outside access");
  a_ready_answer: assert property (psel && !penable && ce |=> pready)
    else $error("no answer after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("slverr without ready");
  a_roles_fixed: assert property (straps_valid && vv |-> $stable(ro))
    else $error("roles changed");
  a_valid_holds: assert property (straps_valid |=> straps_valid)
    else $error("valid dropped");
  a_role_decode: assert property ($rose(straps_valid) |->
    f1_parallel == (mode_pins == 3'h1 || mode_pins == 3'h5) &&
    f1_local_bus == (mode_pins == 3'h0 || mode_pins == 3'h3 || mode_pins == 3'h4))
    else $error("bad role decode");
  a_form_strap: assert property ($rose(straps_valid) && enhanced_mode |->
    bus_form_strap == gp_in[11])
    else $error("form strap not followed");
  a_pin0_low: assert property (vv && straps_valid && f1_parallel |-> gp_oe[0] && !gp_out[0])
    else $error("pin zero not low");
  a_strap_input: assert property (enhanced_mode |-> !gp_oe[11])
    else $error("strap pin driven");
  a_ssid_idle: assert property (subsys_from_pins |-> gp_oe[10:0] == 11'h000)
    else $error("pins driven in id mode");
  a_alone_idle: assert property (standalone || mode_reserved |-> gp_oe == 12'h000)
    else $error("pins driven standalone");
  a_pwr_gate: assert property (pwr_event_req |-> !(subsys_from_pins || standalone))
    else $error("power event in idle mode");
  cover property ($rose(straps_valid));
  cover property (pready && pslverr);
  cover property ($rose(pwr_event_req));
endmodule

bind pfs_top pfs_chk u_chk (.pclk, .presetn, .ce, .psel, .penable, .pready, .pslverr,
  .mode_pins, .gp_in, .gp_oe, .gp_out, .pwr_event_req, .straps_valid, .f1_local_bus,
  .f1_parallel, .enhanced_mode, .subsys_from_pins, .standalone, .mode_reserved,
  .bus_form_strap);

// ===== tb/testbench.sv
// self-checking bench for the pin function select block
`include "pfs_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, gp_irq, pwr_event_req, e, straps_valid;
  logic        eeprom_clock_out, eeprom_select_out, eeprom_data_out, eeprom_data_in;
  logic        f1_local_bus, f1_parallel, f1_disabled, enhanced_mode, uart_unique_bars;
  logic        subsys_from_pins, standalone, mode_reserved, bus_form_strap;
  logic [2:0]  mode = 0, mode_pins;
  logic [7:0]  paddr = 0;
  logic [11:0] gen = 0, gp_in, gp_out, gp_oe;
  logic [15:0] subsys_id, subsys_vid;
  logic [31:0] pwdata = 0, prdata, id_pins, r;
  logic [6:0]  roles;
  int          fails = 0, n_tests = 0, cyc = 0, seed = 3199;
  assign roles = {f1_local_bus, f1_parallel, enhanced_mode, uart_unique_bars,
                  subsys_from_pins, standalone, mode_reserved};
  pfs_top uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .mode_pins, .id_pins, .gp_in, .gp_out, .gp_oe, .gp_irq,
    .pwr_event_req, .eeprom_clock_out, .eeprom_select_out, .eeprom_data_out,
    .eeprom_data_in, .straps_valid, .f1_local_bus, .f1_parallel, .f1_disabled,
    .enhanced_mode, .uart_unique_bars, .subsys_from_pins, .standalone, .mode_reserved,
    .bus_form_strap, .subsys_id, .subsys_vid);
  pfs_board brd (.mode, .gen, .mode_pins, .id_pins, .gp_in, .eeprom_clock_out,
    .eeprom_select_out, .eeprom_data_out, .eeprom_data_in);
  always #10 pclk = ~pclk;
  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [6:0] exp_roles(input logic [2:0] m);
    exp_roles = {m == 0 || m == 3 || m == 4, m == 1 || m == 5, m > 2 && m < 6, m == 3,
                 m == 2, m == 7, m == 6};
  endfunction
  function automatic logic [23:0] exp_pins(input logic [2:0] m, input logic [7:0] c,
                                           input logic [11:0] d, input logic [11:0] v);
    logic        g;
    logic [11:0] gm, lo;
    g = m < 6 && m != 2;
    gm = {m < 3, {8{g}}, g && !c[7], g && c[6:5] == 0, m == 0 || m == 3 || m == 4};
    lo = {10'h000, g && c[6:5] != 0, m == 1 || m == 5};
    exp_pins = {(d & gm) | lo, d & v & gm};
  endfunction
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] a, input logic [31:0] x);
    n_tests++;
    if (a !== x) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, a, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic set_mode(input logic [2:0] m);
    int k;
    mode <= m;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    for (k = 0; k < 30 && straps_valid !== 1'b1; k++) @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic report_and_stop;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [2:0]  m;
    logic [7:0]  c;
    logic [11:0] d, v;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      gen <= 12'($random(seed));
      set_mode(m);
      chk(roles, exp_roles(m));
      chk(f1_disabled, m == 2);
      chk(bus_form_strap, (m > 2 && m < 6) ? gen[11] : 1'b0);
      chk({subsys_vid, subsys_id}, m == 2 ? id_pins : 0);
      c = (m == 0) ? 8'h00 : 8'($random(seed));
      d = 12'($random(seed));
      v = 12'($random(seed));
      apb(1, `PFS_ADDR_CFG, c);
      apb(1, `PFS_ADDR_GPDIR, d);
      apb(1, `PFS_ADDR_GPDATA, v);
      // pin registers follow the data register one edge later
      @(posedge pclk);
      chk({gp_oe, gp_out & gp_oe}, exp_pins(m, c, d, v));
      apb(0, `PFS_ADDR_STATUS, 0);
      chk({r[5], r[2:0]}, {1'b1, m});
      mode <= ~m;
      repeat (8) @(posedge pclk);
      chk(roles, exp_roles(m));
    end
    // corner cases in mode 000
    gen <= 12'h004;
    set_mode(3'h0);
    apb(1, `PFS_ADDR_CFG, 8'h80);
    repeat (8) @(posedge pclk);
    chk(pwr_event_req, 1);
    // enable low must freeze the input chain and the request
    ce <= 0;
    gen <= 12'h008;
    repeat (8) @(posedge pclk);
    chk(pwr_event_req, 1);
    ce <= 1;
    gen <= 12'h008;
    repeat (8) @(posedge pclk);
    chk(pwr_event_req, 0);
    apb(1, `PFS_ADDR_GPIRQ, 12'h008);
    repeat (8) @(posedge pclk);
    chk(gp_irq, 1);
    apb(1, `PFS_ADDR_GPIRQ, 0);
    repeat (4) @(posedge pclk);
    chk(gp_irq, 0);
    // eeprom clocked twice, data bit inverted by the model
    apb(1, `PFS_ADDR_EEPROM, 8'h02);
    apb(1, `PFS_ADDR_EEPROM, 8'h03);
    @(posedge pclk);
    chk({eeprom_data_out, eeprom_select_out, eeprom_clock_out}, 3'h3);
    repeat (6) @(posedge pclk);
    apb(0, `PFS_ADDR_EEPROM, 0);
    chk(r[3:0], 4'hb);
    apb(1, `PFS_ADDR_EEPROM, 8'h06);
    apb(1, `PFS_ADDR_EEPROM, 8'h07);
    repeat (6) @(posedge pclk);
    apb(0, `PFS_ADDR_EEPROM, 0);
    chk(r[3:0], 4'h7);
    apb(1, `PFS_ADDR_EEPROM, 0);
    repeat (6) @(posedge pclk);
    apb(0, `PFS_ADDR_EEPROM, 0);
    chk(r[3:0], 4'h8);
    apb(0, 8'h20, 0);
    chk(e, 1);
    chk(r, 0);
    report_and_stop();
  end
endmodule
